// >>> design/lcdtg_timing_gen.sv
// lcd sync timing generator: frame sync, line sync, pixel valid strobe and pixel data
// Function
// - each frame starts with frame sync asserted; frame period spans assertion to assertion.
// - line sync asserts together with frame sync, starting the frame's first line.
// - pixel valid strobe stays low throughout the vertical back porch lines.
// - after the back porch, strobe appears within every active line.
// - front porch lines follow the active lines with the strobe held low.
// - frame sync width programmable in lines, limited to 5 to 15.
// - vertical back porch counted from frame sync assertion, containing the pulse.
// - vertical porches counted in lines, one per line sync pulse.
// - active-low frame sync idles high and goes low at frame start.
// - same vertical order kept even when sync pins are unused.
// - frame sync without a pin is one line wide.
// - front plus back porch must lie within a 10 to 40 line blank.
// - line starts with line sync, then back porch with strobe low.
// - one new pixel presented per pixel clock while the strobe is high.
// - strobe high for exactly the active pixel count, then deasserted.
// - front porch follows the strobe; next line sync ends the line.
// - line period equals active pixels plus both horizontal porches.
// - line sync and frame sync polarity each selectable.
`timescale 1ns/1ps
module lcdtg_timing_gen
  import lcdtg_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic pixel_clock_i,
  input wire lcdtg_cfg_t cfg_i,
  input wire logic [PIX_W-1:0] pixel_data_i,
  output logic pixel_req_o,
  output logic cfg_error_o,
  output lcdtg_pins_t pins_o
);

  lcdtg_state_t st_q;
  lcdtg_state_t st_d;
  logic [CNT_W-1:0] h_back;
  logic [CNT_W-1:0] app;
  logic [CNT_W-1:0] h_front;
  logic [CNT_W-1:0] lsw;
  logic [CNT_W-1:0] v_back;
  logic [CNT_W-1:0] alc;
  logic [CNT_W-1:0] v_front;
  logic [CNT_W-1:0] fsw_eff;
  logic [CNT_W-1:0] htot;
  logic [CNT_W-1:0] vtot;
  logic [CNT_W-1:0] vblank;
  logic [CNT_W-1:0] h_n;
  logic [CNT_W-1:0] v_n;
  logic tick;
  logic line_active_n;
  logic strobe_n;
  logic fs_n;
  logic ls_n;
  logic err_n;

  always_comb
  begin
    h_back = cfg_i.horizontal_back_porch;
    app = cfg_i.active_pixel_count;
    h_front = cfg_i.horizontal_front_porch;
    lsw = cfg_i.line_sync_width;
    v_back = cfg_i.vertical_back_porch;
    alc = cfg_i.active_line_count;
    v_front = cfg_i.vertical_front_porch;
    // width limited to its legal span; an unpinned sync is only a one-line reference
    if (!cfg_i.frame_sync_pin_used)
    begin
      fsw_eff = FSW_NOPIN;
    end
    else if (cfg_i.frame_sync_width < FSW_MIN)
    begin
      fsw_eff = FSW_MIN;
    end
    else if (cfg_i.frame_sync_width > FSW_MAX)
    begin
      fsw_eff = FSW_MAX;
    end
    else
    begin
      fsw_eff = cfg_i.frame_sync_width;
    end
    htot = h_back + app + h_front;
    vtot = v_back + alc + v_front;
    vblank = v_back + v_front;
    // flagged, not corrected: software owns the split of the blank
    err_n = (vblank < VBLANK_MIN) || (vblank > VBLANK_MAX) || (v_back < fsw_eff);
  end

  // edge found on the second synchroniser stage only
  always_comb
  begin
    tick = st_q.clk_sync2 & ~st_q.clk_prev;
    if (!st_q.running)
    begin
      // first pixel clock after reset lands on the frame's first pixel
      h_n = CNT_ZERO;
      v_n = CNT_ZERO;
    end
    else if (st_q.h >= htot - CNT_ONE)
    begin
      h_n = CNT_ZERO;
      if (st_q.v >= vtot - CNT_ONE)
      begin
        v_n = CNT_ZERO;
      end
      else
      begin
        v_n = st_q.v + CNT_ONE;
      end
    end
    else
    begin
      h_n = st_q.h + CNT_ONE;
      v_n = st_q.v;
    end
    // porch counted from the frame sync assertion, so the pulse lies inside it
    line_active_n = (v_n >= v_back) && (v_n < v_back + alc);
    strobe_n = line_active_n && (h_n >= h_back) && (h_n < h_back + app);
    fs_n = v_n < fsw_eff;
    ls_n = h_n < lsw;
  end

  always_comb
  begin
    st_d = st_q;
    st_d.clk_sync1 = pixel_clock_i;
    st_d.clk_sync2 = st_q.clk_sync1;
    st_d.clk_prev = st_q.clk_sync2;
    st_d.pixel_req = 1'b0;
    st_d.cfg_err = err_n;
    if (tick)
    begin
      st_d.running = 1'b1;
      st_d.h = h_n;
      st_d.v = v_n;
      st_d.fs_act = fs_n;
      st_d.ls_act = ls_n;
      st_d.strobe = strobe_n;
      st_d.pixel_req = strobe_n;
      // blank data outside the active area; the panel ignores it anyway
      st_d.pins.data = strobe_n ? pixel_data_i : '0;
      st_d.pins.pixel_valid_strobe = strobe_n;
      st_d.pins.frame_sync = fs_n ~^ cfg_i.frame_sync_active_high;
      st_d.pins.line_sync = ls_n ~^ cfg_i.line_sync_active_high;
    end
    if (reset_i)
    begin
      st_d = '0;
      st_d.pins.frame_sync = ~cfg_i.frame_sync_active_high;
      st_d.pins.line_sync = ~cfg_i.line_sync_active_high;
    end
  end

  always_ff @(posedge clk_i)
  begin
    st_q <= st_d;
  end

  assign pins_o = st_q.pins;
  assign pixel_req_o = st_q.pixel_req;
  assign cfg_error_o = st_q.cfg_err;

  // strobe length in pixel clocks, read only by the checks below
  logic [CNT_W-1:0] strobe_len_q;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      strobe_len_q <= CNT_ZERO;
    end
    else if (tick && st_d.strobe)
    begin
      strobe_len_q <= st_q.strobe ? strobe_len_q + CNT_ONE : CNT_ONE;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_line_end;
    tick && st_q.running && (st_q.h == htot - CNT_ONE);
  endsequence

  sequence s_frame_end;
    s_line_end ##0 (st_q.v == vtot - CNT_ONE);
  endsequence

  property p_line_wrap;
    s_line_end |=> (st_q.h == CNT_ZERO) && st_q.ls_act == (lsw != CNT_ZERO);
  endproperty
  a_line_wrap: assert property (p_line_wrap)
    else $error("line did not wrap at its total");

  property p_frame_wrap;
    s_frame_end |=> (st_q.v == CNT_ZERO) && st_q.fs_act;
  endproperty
  a_frame_wrap: assert property (p_frame_wrap)
    else $error("frame did not restart with frame sync");

  property p_frame_start;
    $rose(st_q.fs_act) |-> (st_q.v == CNT_ZERO) && (st_q.h == CNT_ZERO);
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("frame sync rose away from frame start");

  property p_line_with_frame;
    $rose(st_q.fs_act) |-> st_q.ls_act || (lsw == CNT_ZERO);
  endproperty
  a_line_with_frame: assert property (p_line_with_frame)
    else $error("line sync missing at frame start");

  property p_v_back_quiet;
    st_q.running && (st_q.v < v_back) |-> !st_q.strobe && !pins_o.pixel_valid_strobe;
  endproperty
  a_v_back_quiet: assert property (p_v_back_quiet)
    else $error("strobe during vertical back porch");

  property p_v_front_quiet;
    st_q.running && (st_q.v >= v_back + alc) |-> !st_q.strobe;
  endproperty
  a_v_front_quiet: assert property (p_v_front_quiet)
    else $error("strobe during vertical front porch");

  property p_h_back_quiet;
    st_q.running && (st_q.h < h_back) |-> !st_q.strobe;
  endproperty
  a_h_back_quiet: assert property (p_h_back_quiet)
    else $error("strobe during horizontal back porch");

  property p_strobe_width;
    $fell(st_q.strobe) |-> strobe_len_q == app;
  endproperty
  a_strobe_width: assert property (p_strobe_width)
    else $error("strobe width differs from active pixel count");

  property p_fs_width;
    st_q.fs_act |-> (st_q.v < fsw_eff) && (fsw_eff <= FSW_MAX);
  endproperty
  a_fs_width: assert property (p_fs_width)
    else $error("frame sync wider than programmed");

  property p_idle_level;
    !st_q.fs_act |-> pins_o.frame_sync == ~cfg_i.frame_sync_active_high;
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("frame sync idle level wrong");

  property p_pixel;
    pixel_req_o |-> pins_o.pixel_valid_strobe ##1 !pixel_req_o;
  endproperty
  a_pixel: assert property (p_pixel)
    else $error("pixel request not a single pulse inside the strobe");

  // the panel may latch at any point of the pixel period, so pins move on ticks only
  property p_pins_hold;
    !tick |=> $stable(pins_o);
  endproperty
  a_pins_hold: assert property (p_pins_hold)
    else $error("pins moved between pixel clocks");

  property p_data_blank;
    !pins_o.pixel_valid_strobe |-> pins_o.data == {PIX_W{1'b0}};
  endproperty
  a_data_blank: assert property (p_data_blank)
    else $error("pixel data not blanked outside the active area");

  property p_pixel_take;
    tick && strobe_n |=> pixel_req_o && (pins_o.data == $past(pixel_data_i));
  endproperty
  a_pixel_take: assert property (p_pixel_take)
    else $error("active pixel not taken from the source");

  property p_first_active;
    tick && (v_n == v_back) && (h_n == h_back) && (alc != CNT_ZERO) && (app != CNT_ZERO)
      |=> pins_o.pixel_valid_strobe;
  endproperty
  a_first_active: assert property (p_first_active)
    else $error("strobe missing at first active pixel");

  property p_blank_range;
    (vblank < VBLANK_MIN) || (vblank > VBLANK_MAX) |=> cfg_error_o;
  endproperty
  a_blank_range: assert property (p_blank_range)
    else $error("blank outside its range not flagged");

  property p_sync_in_porch;
    v_back < fsw_eff |=> cfg_error_o;
  endproperty
  a_sync_in_porch: assert property (p_sync_in_porch)
    else $error("frame sync longer than back porch not flagged");

  property p_frame_pin;
    st_q.fs_act |-> pins_o.frame_sync == cfg_i.frame_sync_active_high;
  endproperty
  a_frame_pin: assert property (p_frame_pin)
    else $error("frame sync active level wrong");

  property p_line_pin;
    st_q.ls_act |-> pins_o.line_sync == cfg_i.line_sync_active_high;
  endproperty
  a_line_pin: assert property (p_line_pin)
    else $error("line sync active level wrong");

endmodule

// >>> design/lcdtg_pkg.sv
// shared widths, limits and carrier types of the lcd sync timing generator
package lcdtg_pkg;

  localparam int unsigned CNT_W = 12;
  localparam int unsigned PIX_W = 18;

  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  localparam logic [CNT_W-1:0] FSW_MIN = 12'h005;
  localparam logic [CNT_W-1:0] FSW_MAX = 12'h00F;
  localparam logic [CNT_W-1:0] FSW_NOPIN = 12'h001;
  localparam logic [CNT_W-1:0] VBLANK_MIN = 12'h00A;
  localparam logic [CNT_W-1:0] VBLANK_MAX = 12'h028;

  typedef struct packed {
    logic [CNT_W-1:0] active_pixel_count;
    logic [CNT_W-1:0] horizontal_back_porch;
    logic [CNT_W-1:0] horizontal_front_porch;
    logic [CNT_W-1:0] line_sync_width;
    logic [CNT_W-1:0] active_line_count;
    logic [CNT_W-1:0] vertical_back_porch;
    logic [CNT_W-1:0] vertical_front_porch;
    logic [CNT_W-1:0] frame_sync_width;
    logic frame_sync_pin_used;
    logic line_sync_active_high;
    logic frame_sync_active_high;
  } lcdtg_cfg_t;

  typedef struct packed {
    logic frame_sync;
    logic line_sync;
    logic pixel_valid_strobe;
    logic [PIX_W-1:0] data;
  } lcdtg_pins_t;

  typedef struct packed {
    logic clk_sync1;
    logic clk_sync2;
    logic clk_prev;
    logic running;
    logic [CNT_W-1:0] h;
    logic [CNT_W-1:0] v;
    logic fs_act;
    logic ls_act;
    logic strobe;
    logic pixel_req;
    logic cfg_err;
    lcdtg_pins_t pins;
  } lcdtg_state_t;

endpackage

// >>> tb/lcdtg_panel_model.sv
// behavioural dumb panel that latches pixels while the valid strobe is high
`timescale 1ns/1ps
module lcdtg_panel_model
  import lcdtg_pkg::*;
(
  input wire logic pixel_clock_i,
  input wire logic reset_i,
  input wire lcdtg_pins_t pins_i,
  output logic [15:0] pixel_count_o,
  output logic [PIX_W-1:0] last_data_o
);
  // latch on the rising pixel clock, a few clk_i cycles less than a period after the bus last moved
  always @(posedge pixel_clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pixel_count_o <= 16'h0000;
      last_data_o <= {PIX_W{1'b0}};
    end
    else if (pins_i.pixel_valid_strobe)
    begin
      pixel_count_o <= pixel_count_o + 16'h0001;
      last_data_o <= pins_i.data;
    end
  end
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the lcd sync timing generator
`timescale 1ns/1ps
module tb_top;
  import lcdtg_pkg::*;
  logic clk_i, reset_i, pixel_clock_i, pixel_req_o, cfg_error_o;
  lcdtg_cfg_t cfg, base;
  lcdtg_pins_t pins_o;
  logic [PIX_W-1:0] src, pan_data;
  logic [15:0] pan_cnt;
  int failures, checks, req_cnt, exp_k;

  lcdtg_timing_gen uut (.clk_i(clk_i), .reset_i(reset_i), .pixel_clock_i(pixel_clock_i),
    .cfg_i(cfg), .pixel_data_i(src), .pixel_req_o(pixel_req_o),
    .cfg_error_o(cfg_error_o), .pins_o(pins_o));
  lcdtg_panel_model panel (.pixel_clock_i(pixel_clock_i), .reset_i(reset_i),
    .pins_i(pins_o), .pixel_count_o(pan_cnt), .last_data_o(pan_data));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // odd start offset keeps the pixel clock edges off the clk_i edges; its period is 8 clk_i periods
  initial
  begin
    pixel_clock_i = 1'b0;
    #7;
    forever #160 pixel_clock_i = ~pixel_clock_i;
  end

  // pixel source: next value after each request pulse
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      src <= 18'h00000;
      req_cnt <= 0;
    end
    else if (pixel_req_o === 1'b1)
    begin
      src <= src + 18'h00001;
      req_cnt <= req_cnt + 1;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // release just after a pixel clock fall so the next rise is position 0
  task automatic do_reset(input lcdtg_cfg_t c);
    @(posedge clk_i);
    cfg <= c;
    reset_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    @(negedge pixel_clock_i);
    @(posedge clk_i);
    reset_i <= 1'b0;
    exp_k = 0;
    #1;
  endtask

  task automatic scan(input int frames);
    int fsw, ht, vt, h, v, p;
    logic on;
    lcdtg_pins_t e;
    fsw = !cfg.frame_sync_pin_used ? 1 : cfg.frame_sync_width < 5 ? 5 :
      cfg.frame_sync_width > 15 ? 15 : int'(cfg.frame_sync_width);
    ht = cfg.horizontal_back_porch + cfg.active_pixel_count + cfg.horizontal_front_porch;
    vt = cfg.vertical_back_porch + cfg.active_line_count + cfg.vertical_front_porch;
    for (p = 0; p <= frames * ht * vt; p++)
    begin
      h = p % ht;
      v = (p / ht) % vt;
      on = v >= cfg.vertical_back_porch && v < cfg.vertical_back_porch + cfg.active_line_count
        && h >= cfg.horizontal_back_porch
        && h < cfg.horizontal_back_porch + cfg.active_pixel_count;
      e.frame_sync = (v < fsw) ~^ cfg.frame_sync_active_high;
      e.line_sync = (h < cfg.line_sync_width) ~^ cfg.line_sync_active_high;
      e.pixel_valid_strobe = on;
      e.data = on ? PIX_W'(exp_k) : {PIX_W{1'b0}};
      @(posedge pixel_clock_i);
      repeat (5) @(posedge clk_i);
      #1;
      check("pins", 32'(pins_o), 32'(e));
      if (on)
        exp_k++;
    end
    check("pixel requests", 32'(req_cnt), 32'(exp_k));
    check("panel count", 32'(pan_cnt), 32'(exp_k));
    check("panel data", 32'(pan_data), 32'(exp_k - 1));
  endtask

  task automatic t_basic();
    do_reset(base);
    check("idle", 32'({pixel_req_o, cfg_error_o, pins_o}), 32'({5'h06, 18'h00000}));
    scan(2);
  endtask

  // oversized width clamps to 15 lines; both polarities active high
  task automatic t_clamp_high();
    lcdtg_cfg_t c;
    c = base;
    c.frame_sync_width = 12'h014;
    c.vertical_back_porch = 12'h00F;
    c.line_sync_active_high = 1'b1;
    c.frame_sync_active_high = 1'b1;
    do_reset(c);
    scan(1);
  endtask

  task automatic t_nopin();
    lcdtg_cfg_t c;
    c = base;
    c.frame_sync_pin_used = 1'b0;
    c.frame_sync_width = 12'h009;
    c.line_sync_active_high = 1'b1;
    do_reset(c);
    scan(1);
  endtask

  // blank sums 9, 41, 10, 40, and back porch shorter than the sync width
  task automatic t_cfg_err();
    logic [11:0] tb [5] = '{12'h005, 12'h014, 12'h005, 12'h014, 12'h006};
    logic [11:0] tf [5] = '{12'h004, 12'h015, 12'h005, 12'h014, 12'h006};
    logic [11:0] tw [5] = '{12'h005, 12'h005, 12'h005, 12'h005, 12'h008};
    logic te [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    // back to the pinned base: an unpinned sync would hide the width case
    do_reset(base);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk_i);
      cfg.vertical_back_porch <= tb[i];
      cfg.vertical_front_porch <= tf[i];
      cfg.frame_sync_width <= tw[i];
      repeat (2) @(posedge clk_i);
      #1;
      check("cfg error", 32'(cfg_error_o), 32'(te[i]));
    end
  endtask

  initial
  begin
    failures = 0;
    checks = 0;
    exp_k = 0;
    reset_i = 1'b1;
    base = {12'h004, 12'h003, 12'h002, 12'h001, 12'h003, 12'h005, 12'h005, 12'h005, 3'b100};
    cfg = base;
    t_basic();
    t_clamp_high();
    t_nopin();
    t_cfg_err();
    wrap_up();
  end

  initial
  begin
    #600000;
    failures++;
    wrap_up();
  end
endmodule
